// [dat_regs.svh]
// Offsets, reset values, masks and field positions of the active-timing view
`ifndef DAT_REGS_SVH
`define DAT_REGS_SVH

// --------
// Register offsets (byte addresses)
// --------
`define DAT_OFF_RANK_MAP     16'h11F8
`define DAT_OFF_SCRUB        16'h11FC
`define DAT_OFF_REFI         16'h1200
`define DAT_OFF_RFC          16'h1204
`define DAT_OFF_MRR          16'h1208
`define DAT_OFF_MRW          16'h120C
`define DAT_OFF_RDPDEN       16'h1210
`define DAT_OFF_RCD          16'h1218
`define DAT_OFF_RAS          16'h121C

// --------
// Reset values
// --------
`define DAT_RST_RANK_MAP     32'h76543210
`define DAT_RST_SCRUB        32'h00001F00
`define DAT_RST_REFI         32'h00090100
`define DAT_RST_RFC          32'h00008C23
`define DAT_RST_MRR          32'h00000002
`define DAT_RST_MRW          32'h0000000C
`define DAT_RST_RDPDEN       32'h0000000A
`define DAT_RST_RCD          32'h00000005
`define DAT_RST_RAS          32'h0000000E
`define DAT_RD_IDLE          32'h00000000

// --------
// Writable-field masks
// --------
`define DAT_MSK_SCRUB        32'h00007F07
`define DAT_MSK_REFI         32'h000007FF
`define DAT_MSK_RFC          32'h0FFFFFFF
`define DAT_MSK_MRR          32'h0000007F
`define DAT_MSK_MRW          32'h0000007F
`define DAT_MSK_RDPDEN       32'h0000007F
`define DAT_MSK_RCD          32'h0000001F
`define DAT_MSK_RAS          32'h0000003F

// --------
// Field positions
// --------
`define DAT_MAP_FIELD_W      4
`define DAT_MAP_MASK_BIT     3
`define DAT_MAP_TGT_W        3
`define DAT_F_SCRUB_LIMIT    14:8
`define DAT_F_SCRUB_PRESC    2:0
`define DAT_F_RFC_AB         9:0
`define DAT_F_RFC_FG         19:10
`define DAT_F_RFC_CS         27:20
`define DAT_F_MRR            6:0
`define DAT_F_MRW            6:0
`define DAT_F_RDPDEN         6:0
`define DAT_F_RCD            4:0
`define DAT_F_RAS            5:0

`endif

// [dat_pkg.sv]
// Types shared by the active-timing and rank-map block
package dat_pkg;

    // --------
    // Controller operating states
    // --------
    typedef enum logic [1:0] {
        mode_config,
        mode_low_power,
        state_a,
        mode_ready
    } dat_mode_type;

    // --------
    // Scheduler command kinds
    // --------
    typedef enum logic [3:0] {
        cmd_nop,
        cmd_activate,
        cmd_read,
        cmd_write,
        cmd_precharge,
        cmd_refresh_all,
        cmd_refresh_fine,
        cmd_mode_read,
        cmd_mode_write,
        cmd_power_down
    } dat_cmd_type;

    // --------
    // Whole state of the block
    // --------
    typedef struct packed {
        logic [31:0]       rank_map;
        logic [31:0]       scrub;
        logic [31:0]       refi;
        logic [31:0]       rfc;
        logic [31:0]       mrr;
        logic [31:0]       mrw;
        logic [31:0]       rdpden;
        logic [31:0]       rcd;
        logic [31:0]       ras;
        logic [7:0][9:0]   rank_lock;
        logic [7:0][6:0]   pd_hold;
        logic [63:0][4:0]  rcd_cnt;
        logic [63:0][5:0]  ras_cnt;
        logic [7:0]        ref_cs_cnt;
        logic [2:0]        last_ref_rank;
        logic              ref_seen;
        logic [6:0]        mrr_cnt;
        logic              mrr_busy;
        logic              mrr_data;
        logic [6:0]        scrub_count;
        logic [2:0]        presc_cnt;
        logic              esc_tick;
        logic [31:0]       rd_data;
        logic              wr_reject;
        logic              resp_valid;
        logic [2:0]        resp_rank;
        logic              resp_abort;
    } dat_state_type;

endpackage

// [dat_core.sv]
// Active timing registers, rank map and command spacing checks
//
// Added by the designer: the strobed register port.
`include "dat_regs.svh"

// Notes on behaviour
// - Masked rank address aborts every transaction
// - Three-bit field remaps each rank address
// - Registers readable always, writes rejected, windowed updates
// - Scrub register updates only in config/low-power
// - Outstanding scrub requests capped by seven-bit limit
// - One escalation prescaler period for all programs
// - All-bank refresh locks rank for recovery delay
// - Fine-grained refresh locks rank for own delay
// - Refreshes to different ranks spaced by delay
// - Mode read locks rank, marks returned data
// - Mode write locks rank for write delay
// - Read holds off power-down for delay
// - Activate to read/write spacing per bank
// - Activate to precharge spacing per bank
// - Activate-to-precharge field is six bits
module dat_core (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    // Software register port
    input  wire logic [15:0]          reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic      [31:0]          reg_rdata_out,
    output logic                      reg_wr_reject_out,
    // Staged configuration update
    input  wire dat_pkg::dat_mode_type ctrl_mode_in,
    input  wire logic                 stage_valid_in,
    input  wire logic [15:0]          stage_addr_in,
    input  wire logic [31:0]          stage_data_in,
    output logic                      stage_ready_out,
    // Transaction rank lookup
    input  wire logic                 req_valid_in,
    input  wire logic [2:0]           req_rank_in,
    output logic                      resp_valid_out,
    output logic      [2:0]           resp_phys_rank_out,
    output logic                      resp_abort_out,
    // Scheduler command check
    input  wire logic                 cmd_valid_in,
    input  wire dat_pkg::dat_cmd_type cmd_type_in,
    input  wire logic [2:0]           cmd_rank_in,
    input  wire logic [2:0]           cmd_bank_in,
    output logic                      cmd_allowed_out,
    output logic                      mrr_data_out,
    // Scrub engine limits
    input  wire logic                 scrub_req_in,
    input  wire logic                 scrub_done_in,
    output logic                      scrub_grant_out,
    output logic      [6:0]           scrub_outstanding_out,
    output logic                      scrub_esc_tick_out
);

    dat_pkg::dat_state_type st;
    dat_pkg::dat_state_type next_st;

    logic [7:0]      rank_blocked;
    logic [7:0][2:0] rank_target;
    logic [7:0]      rank_free;
    logic            win_all;
    logic            win_scrub;
    logic [5:0]      bank_idx;
    logic            issue;
    logic            scrub_issue;

    // Delay D is met D cycles after issue: load D-1, free at zero
    function automatic logic [9:0] dat_load(input logic [9:0] d);
        dat_load = (d == 10'h000) ? 10'h000 : d - 10'h001;
    endfunction

    // --------
    // Per-rank decode of the rank map and lockout state
    // --------
    for (genvar g = 0; g < 8; g++) begin : g_rank
        assign rank_blocked[g] =
            st.rank_map[g * `DAT_MAP_FIELD_W + `DAT_MAP_MASK_BIT];
        assign rank_target[g]  =
            st.rank_map[g * `DAT_MAP_FIELD_W +: `DAT_MAP_TGT_W];
        assign rank_free[g]    = (st.rank_lock[g] == 10'h000);
    end

    // --------
    // Update windows
    // --------
    assign win_all   = (ctrl_mode_in == dat_pkg::mode_config)
                    || (ctrl_mode_in == dat_pkg::mode_low_power)
                    || (ctrl_mode_in == dat_pkg::state_a);
    assign win_scrub = (ctrl_mode_in == dat_pkg::mode_config)
                    || (ctrl_mode_in == dat_pkg::mode_low_power);
    assign stage_ready_out = (stage_addr_in == `DAT_OFF_SCRUB)
                           ? win_scrub : win_all;

    // --------
    // Command spacing check
    // --------
    assign bank_idx = {cmd_rank_in, cmd_bank_in};

    always_comb begin
        cmd_allowed_out = 1'b0;
        if (cmd_valid_in && rank_free[cmd_rank_in]) begin
            case (cmd_type_in)
                dat_pkg::cmd_read,
                dat_pkg::cmd_write: begin
                    cmd_allowed_out = (st.rcd_cnt[bank_idx] == 5'h00);
                end
                dat_pkg::cmd_precharge: begin
                    cmd_allowed_out = (st.ras_cnt[bank_idx] == 6'h00);
                end
                dat_pkg::cmd_refresh_all,
                dat_pkg::cmd_refresh_fine: begin
                    cmd_allowed_out = !st.ref_seen
                                   || (cmd_rank_in == st.last_ref_rank)
                                   || (st.ref_cs_cnt == 8'h00);
                end
                dat_pkg::cmd_power_down: begin
                    cmd_allowed_out = (st.pd_hold[cmd_rank_in] == 7'h00);
                end
                default: begin
                    cmd_allowed_out = 1'b1;
                end
            endcase
        end
    end

    assign issue       = cmd_valid_in && cmd_allowed_out;
    // A zero limit is unsupported and grants nothing
    assign scrub_grant_out = (st.scrub_count < st.scrub[`DAT_F_SCRUB_LIMIT]);
    assign scrub_issue = scrub_req_in && scrub_grant_out;

    // --------
    // Next-state logic
    // --------
    always_comb begin
        logic [9:0] ld;
        ld = 10'h000;
        next_st = st;
        next_st.rd_data    = `DAT_RD_IDLE;
        next_st.wr_reject  = 1'b0;
        next_st.mrr_data   = 1'b0;
        next_st.esc_tick   = 1'b0;
        next_st.resp_valid = 1'b0;
        next_st.resp_abort = 1'b0;

        // Software reads see the held values; writes never land
        if (reg_rd_in) begin
            if (reg_addr_in == `DAT_OFF_RANK_MAP) begin
                next_st.rd_data = st.rank_map;
            end else if (reg_addr_in == `DAT_OFF_SCRUB) begin
                next_st.rd_data = st.scrub;
            end else if (reg_addr_in == `DAT_OFF_REFI) begin
                next_st.rd_data = st.refi;
            end else if (reg_addr_in == `DAT_OFF_RFC) begin
                next_st.rd_data = st.rfc;
            end else if (reg_addr_in == `DAT_OFF_MRR) begin
                next_st.rd_data = st.mrr;
            end else if (reg_addr_in == `DAT_OFF_MRW) begin
                next_st.rd_data = st.mrw;
            end else if (reg_addr_in == `DAT_OFF_RDPDEN) begin
                next_st.rd_data = st.rdpden;
            end else if (reg_addr_in == `DAT_OFF_RCD) begin
                next_st.rd_data = st.rcd;
            end else if (reg_addr_in == `DAT_OFF_RAS) begin
                next_st.rd_data = st.ras;
            end
        end
        next_st.wr_reject = reg_wr_in;

        // Staged values; reserved bits keep their reset pattern
        if (stage_valid_in && stage_ready_out) begin
            if (stage_addr_in == `DAT_OFF_RANK_MAP) begin
                next_st.rank_map = stage_data_in;
            end else if (stage_addr_in == `DAT_OFF_SCRUB) begin
                next_st.scrub = (stage_data_in & `DAT_MSK_SCRUB)
                              | (`DAT_RST_SCRUB & ~`DAT_MSK_SCRUB);
            end else if (stage_addr_in == `DAT_OFF_REFI) begin
                next_st.refi = (stage_data_in & `DAT_MSK_REFI)
                             | (`DAT_RST_REFI & ~`DAT_MSK_REFI);
            end else if (stage_addr_in == `DAT_OFF_RFC) begin
                next_st.rfc = (stage_data_in & `DAT_MSK_RFC)
                            | (`DAT_RST_RFC & ~`DAT_MSK_RFC);
            end else if (stage_addr_in == `DAT_OFF_MRR) begin
                next_st.mrr = (stage_data_in & `DAT_MSK_MRR)
                            | (`DAT_RST_MRR & ~`DAT_MSK_MRR);
            end else if (stage_addr_in == `DAT_OFF_MRW) begin
                next_st.mrw = (stage_data_in & `DAT_MSK_MRW)
                            | (`DAT_RST_MRW & ~`DAT_MSK_MRW);
            end else if (stage_addr_in == `DAT_OFF_RDPDEN) begin
                next_st.rdpden = (stage_data_in & `DAT_MSK_RDPDEN)
                               | (`DAT_RST_RDPDEN & ~`DAT_MSK_RDPDEN);
            end else if (stage_addr_in == `DAT_OFF_RCD) begin
                next_st.rcd = (stage_data_in & `DAT_MSK_RCD)
                            | (`DAT_RST_RCD & ~`DAT_MSK_RCD);
            end else if (stage_addr_in == `DAT_OFF_RAS) begin
                next_st.ras = (stage_data_in & `DAT_MSK_RAS)
                            | (`DAT_RST_RAS & ~`DAT_MSK_RAS);
            end
        end

        // Rank lookup, one cycle of latency
        next_st.resp_valid = req_valid_in;
        if (req_valid_in) begin
            next_st.resp_rank  = rank_target[req_rank_in];
            next_st.resp_abort = rank_blocked[req_rank_in];
        end

        // Every timer counts controller clock cycles down to zero
        for (int i = 0; i < 8; i++) begin
            if (st.rank_lock[i] != 10'h000) begin
                next_st.rank_lock[i] = st.rank_lock[i] - 10'h001;
            end
            if (st.pd_hold[i] != 7'h00) begin
                next_st.pd_hold[i] = st.pd_hold[i] - 7'h01;
            end
        end
        for (int j = 0; j < 64; j++) begin
            if (st.rcd_cnt[j] != 5'h00) begin
                next_st.rcd_cnt[j] = st.rcd_cnt[j] - 5'h01;
            end
            if (st.ras_cnt[j] != 6'h00) begin
                next_st.ras_cnt[j] = st.ras_cnt[j] - 6'h01;
            end
        end
        if (st.ref_cs_cnt != 8'h00) begin
            next_st.ref_cs_cnt = st.ref_cs_cnt - 8'h01;
        end
        if (st.mrr_busy) begin
            if (st.mrr_cnt == 7'h00) begin
                next_st.mrr_busy = 1'b0;
                next_st.mrr_data = 1'b1;
            end else begin
                next_st.mrr_cnt = st.mrr_cnt - 7'h01;
            end
        end

        // Loads on an issued command override the countdown
        if (issue) begin
            case (cmd_type_in)
                dat_pkg::cmd_activate: begin
                    ld = dat_load({5'h00, st.rcd[`DAT_F_RCD]});
                    next_st.rcd_cnt[bank_idx] = ld[4:0];
                    ld = dat_load({4'h0, st.ras[`DAT_F_RAS]});
                    next_st.ras_cnt[bank_idx] = ld[5:0];
                end
                dat_pkg::cmd_read: begin
                    ld = dat_load({3'h0, st.rdpden[`DAT_F_RDPDEN]});
                    next_st.pd_hold[cmd_rank_in] = ld[6:0];
                end
                dat_pkg::cmd_refresh_all,
                dat_pkg::cmd_refresh_fine: begin
                    if (cmd_type_in == dat_pkg::cmd_refresh_all) begin
                        next_st.rank_lock[cmd_rank_in] =
                            dat_load(st.rfc[`DAT_F_RFC_AB]);
                    end else begin
                        next_st.rank_lock[cmd_rank_in] =
                            dat_load(st.rfc[`DAT_F_RFC_FG]);
                    end
                    // Zero spacing leaves other ranks free next cycle
                    ld = dat_load({2'h0, st.rfc[`DAT_F_RFC_CS]});
                    next_st.ref_cs_cnt    = ld[7:0];
                    next_st.last_ref_rank = cmd_rank_in;
                    next_st.ref_seen      = 1'b1;
                end
                dat_pkg::cmd_mode_read: begin
                    ld = dat_load({3'h0, st.mrr[`DAT_F_MRR]});
                    next_st.rank_lock[cmd_rank_in] = ld;
                    next_st.mrr_cnt  = ld[6:0];
                    next_st.mrr_busy = 1'b1;
                end
                dat_pkg::cmd_mode_write: begin
                    next_st.rank_lock[cmd_rank_in] =
                        dat_load({3'h0, st.mrw[`DAT_F_MRW]});
                end
                default: begin
                end
            endcase
        end

        // Outstanding scrub count; a completion with none open is dropped
        if (scrub_issue && !(scrub_done_in && st.scrub_count != 7'h00)) begin
            next_st.scrub_count = st.scrub_count + 7'h01;
        end else if (!scrub_issue && scrub_done_in
                     && st.scrub_count != 7'h00) begin
            next_st.scrub_count = st.scrub_count - 7'h01;
        end

        // Shared escalation tick every (period + 1) cycles
        if (st.presc_cnt == 3'h0) begin
            next_st.presc_cnt = st.scrub[`DAT_F_SCRUB_PRESC];
            next_st.esc_tick  = 1'b1;
        end else begin
            next_st.presc_cnt = st.presc_cnt - 3'h1;
        end
    end

    // --------
    // State register
    // --------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st               <= '0;
            st.rank_map      <= `DAT_RST_RANK_MAP;
            st.scrub         <= `DAT_RST_SCRUB;
            st.refi          <= `DAT_RST_REFI;
            st.rfc           <= `DAT_RST_RFC;
            st.mrr           <= `DAT_RST_MRR;
            st.mrw           <= `DAT_RST_MRW;
            st.rdpden        <= `DAT_RST_RDPDEN;
            st.rcd           <= `DAT_RST_RCD;
            st.ras           <= `DAT_RST_RAS;
        end else begin
            st <= next_st;
        end
    end

    // --------
    // Outputs
    // --------
    assign reg_rdata_out         = st.rd_data;
    assign reg_wr_reject_out     = st.wr_reject;
    assign resp_valid_out        = st.resp_valid;
    assign resp_phys_rank_out    = st.resp_rank;
    assign resp_abort_out        = st.resp_abort;
    assign mrr_data_out          = st.mrr_data;
    assign scrub_outstanding_out = st.scrub_count;
    assign scrub_esc_tick_out    = st.esc_tick;

endmodule

// [dat_core_assertions.sv]
// Port-level concurrent checks for the active-timing and rank-map block
`include "dat_regs.svh"
module dat_core_assertions (
    input wire logic                 mclk_in, reset_in, reg_wr_in, reg_rd_in,
    input wire logic [31:0]          reg_rdata_out,
    input wire logic                 reg_wr_reject_out, stage_valid_in,
    input wire logic                 stage_ready_out,
    input wire dat_pkg::dat_mode_type ctrl_mode_in,
    input wire logic [15:0]          stage_addr_in,
    input wire logic                 req_valid_in, resp_valid_out,
    input wire logic                 resp_abort_out,
    input wire logic                 cmd_valid_in, cmd_allowed_out,
    input wire dat_pkg::dat_cmd_type cmd_type_in,
    input wire logic [2:0]           cmd_rank_in, cmd_bank_in,
    input wire logic                 scrub_req_in, scrub_done_in,
    input wire logic                 scrub_grant_out,
    input wire logic [6:0]           scrub_outstanding_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // Command taken by the scheduler this cycle
    sequence s_go(dat_pkg::dat_cmd_type k);
        cmd_valid_in && cmd_allowed_out && cmd_type_in == k;
    endsequence

    a_write_refused: assert property (
        reg_wr_reject_out == $past(reg_wr_in)) else $error("write not refused");
    a_read_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == `DAT_RD_IDLE) else $error("stray rdata");
    a_lookup_answer: assert property (
        req_valid_in |=> resp_valid_out) else $error("lookup not answered");
    a_abort_with_resp: assert property (
        resp_abort_out |-> resp_valid_out) else $error("abort without resp");
    a_state_a_scrub: assert property (
        stage_valid_in && stage_addr_in == `DAT_OFF_SCRUB &&
        ctrl_mode_in == dat_pkg::state_a |-> !stage_ready_out)
        else $error("scrub updated while state_a");
    a_scrub_count: assert property (
        scrub_req_in && scrub_grant_out && !scrub_done_in |=>
        scrub_outstanding_out == $past(scrub_outstanding_out) + 7'h01)
        else $error("scrub count not raised");
    a_refresh_lock: assert property (
        s_go(dat_pkg::cmd_refresh_all) ##1
        (cmd_valid_in && cmd_rank_in == $past(cmd_rank_in)) |-> !cmd_allowed_out)
        else $error("command during refresh");
    a_mode_write_lock: assert property (
        s_go(dat_pkg::cmd_mode_write) ##1
        (cmd_valid_in && cmd_rank_in == $past(cmd_rank_in)) |-> !cmd_allowed_out)
        else $error("command after mode write");
    a_act_spacing: assert property (
        s_go(dat_pkg::cmd_activate) ##1 (cmd_type_in == dat_pkg::cmd_read &&
        cmd_valid_in && {cmd_rank_in, cmd_bank_in} ==
        $past({cmd_rank_in, cmd_bank_in})) |-> !cmd_allowed_out)
        else $error("read too soon");
    a_ras_spacing: assert property (
        s_go(dat_pkg::cmd_activate) ##1 (cmd_type_in == dat_pkg::cmd_precharge &&
        cmd_valid_in && {cmd_rank_in, cmd_bank_in} ==
        $past({cmd_rank_in, cmd_bank_in})) |-> !cmd_allowed_out)
        else $error("precharge too soon");
endmodule

bind dat_core dat_core_assertions u_chk (.*);

// [dat_rank_model.sv]
// Far-side rank model: a rank busy in refresh must see no command
module dat_rank_model #(
    parameter int ref_busy = 35
) (
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    input  wire logic                 cmd_valid_in,
    input  wire logic                 cmd_allowed_in,
    input  wire dat_pkg::dat_cmd_type cmd_type_in,
    input  wire logic [2:0]           cmd_rank_in,
    output int                        errors_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy [8];
    always @(posedge mclk_in) begin
        foreach (busy[r]) if (busy[r] > 0) busy[r]--;
        if (reset_in) errors_out <= 0;
        else if (cmd_valid_in && cmd_allowed_in) begin
            if (busy[cmd_rank_in] > 0) errors_out <= errors_out + 1;
            if (cmd_type_in inside {dat_pkg::cmd_refresh_all,
                                    dat_pkg::cmd_refresh_fine})
                busy[cmd_rank_in] = ref_busy;
        end
    end
endmodule

// [dat_core_tb.sv]
// Self-checking bench for the active-timing and rank-map block
`include "dat_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module dat_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic        stage_valid_in = 0, req_valid_in = 0, cmd_valid_in = 0;
    logic        scrub_req_in = 0, scrub_done_in = 0, reg_wr_reject_out;
    logic        stage_ready_out, resp_valid_out, resp_abort_out;
    logic        cmd_allowed_out, mrr_data_out, scrub_grant_out;
    logic        scrub_esc_tick_out;
    logic [15:0] reg_addr_in = 0, stage_addr_in = 0;
    logic [31:0] reg_wdata_in = 0, stage_data_in = 0, reg_rdata_out;
    logic [2:0]  req_rank_in = 0, cmd_rank_in = 0, cmd_bank_in = 0;
    logic [2:0]  resp_phys_rank_out;
    logic [6:0]  scrub_outstanding_out;
    dat_pkg::dat_mode_type ctrl_mode_in = dat_pkg::mode_ready;
    dat_pkg::dat_cmd_type  cmd_type_in = dat_pkg::cmd_nop;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, model_err;
    logic [15:0] offs [9] = '{`DAT_OFF_RANK_MAP, `DAT_OFF_SCRUB, `DAT_OFF_REFI,
        `DAT_OFF_RFC, `DAT_OFF_MRR, `DAT_OFF_MRW, `DAT_OFF_RDPDEN,
        `DAT_OFF_RCD, `DAT_OFF_RAS};
    logic [31:0] rsts [9] = '{`DAT_RST_RANK_MAP, `DAT_RST_SCRUB, `DAT_RST_REFI,
        `DAT_RST_RFC, `DAT_RST_MRR, `DAT_RST_MRW, `DAT_RST_RDPDEN,
        `DAT_RST_RCD, `DAT_RST_RAS};

    dat_core u_dut (.*);
    dat_rank_model u_model (.mclk_in(mclk_in), .reset_in(reset_in),
        .cmd_valid_in(cmd_valid_in), .cmd_allowed_in(cmd_allowed_out),
        .cmd_type_in(cmd_type_in), .cmd_rank_in(cmd_rank_in),
        .errors_out(model_err));

    initial forever #5 mclk_in = ~mclk_in;
    // A hang cannot outlive this many cycles
    always @(posedge mclk_in) if (++cyc == 3000) begin
        n_mismatch++;
        end_sim;
    end

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK("read data", e, reg_rdata_out)
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        #1 `CHK("write refused", 1'b1, reg_wr_reject_out)
    endtask
    task automatic stg(input dat_pkg::dat_mode_type m, input logic [15:0] a,
                       input logic [31:0] d, input logic e);
        @(posedge mclk_in);
        ctrl_mode_in <= m;
        stage_valid_in <= 1'b1;
        stage_addr_in <= a;
        stage_data_in <= d;
        #1 `CHK("stage ready", e, stage_ready_out)
        @(posedge mclk_in);
        stage_valid_in <= 1'b0;
        ctrl_mode_in <= dat_pkg::mode_ready;
    endtask
    task automatic look(input logic [2:0] r, p, input logic ab);
        @(posedge mclk_in);
        req_valid_in <= 1'b1;
        req_rank_in <= r;
        @(posedge mclk_in);
        req_valid_in <= 1'b0;
        #1 `CHK("lookup valid", 1'b1, resp_valid_out)
        `CHK("phys rank", p, resp_phys_rank_out)
        `CHK("abort", ab, resp_abort_out)
    endtask
    // Issue a, then offer b each cycle: refused until exactly d cycles on
    task automatic gap(input dat_pkg::dat_cmd_type a, b, input logic [2:0] k,
                       input int d);
        @(posedge mclk_in);
        cmd_valid_in <= 1'b1;
        cmd_type_in <= a;
        {cmd_rank_in, cmd_bank_in} <= {k, k};
        for (int i = 1; i <= d; i++) begin
            @(posedge mclk_in);
            cmd_type_in <= b;
            #1 `CHK("cmd allowed", i == d, cmd_allowed_out)
        end
        @(posedge mclk_in);
        cmd_valid_in <= 1'b0;
        #1 `CHK("mrr data", a == dat_pkg::cmd_mode_read, mrr_data_out)
        repeat (40) @(posedge mclk_in);
    endtask

    task automatic t_regs;
        for (int i = 0; i < 9; i++) rd(offs[i], rsts[i]);
        rd(16'h1214, `DAT_RD_IDLE);
        wr(`DAT_OFF_RAS, 32'h0000003F);
        rd(`DAT_OFF_RAS, `DAT_RST_RAS);
        stg(dat_pkg::state_a, `DAT_OFF_RAS, 32'hFFFFFFFF, 1'b1);
        rd(`DAT_OFF_RAS, 32'h0000003F);
        stg(dat_pkg::mode_config, `DAT_OFF_RAS, `DAT_RST_RAS, 1'b1);
        stg(dat_pkg::mode_config, `DAT_OFF_REFI, 32'h000007FF, 1'b1);
        $display("registers test done");
    endtask
    task automatic t_map;
        for (int r = 0; r < 8; r++) look(3'(r), 3'(r), 1'b0);
        stg(dat_pkg::mode_ready, `DAT_OFF_RANK_MAP, 32'h76593210, 1'b0);
        stg(dat_pkg::state_a, `DAT_OFF_RANK_MAP, 32'h76593210, 1'b1);
        look(3'h4, 3'h1, 1'b1);
        look(3'h5, 3'h5, 1'b0);
        $display("rank map test done");
    endtask
    task automatic t_scrub;
        int n;
        stg(dat_pkg::state_a, `DAT_OFF_SCRUB, 32'h00000203, 1'b0);
        rd(`DAT_OFF_SCRUB, `DAT_RST_SCRUB);
        stg(dat_pkg::mode_low_power, `DAT_OFF_SCRUB, 32'h00000203, 1'b1);
        @(posedge mclk_in);
        scrub_req_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        scrub_req_in <= 1'b0;
        scrub_done_in <= 1'b1;
        #1 `CHK("scrub count", 7'h02, scrub_outstanding_out)
        `CHK("scrub grant", 1'b0, scrub_grant_out)
        @(posedge mclk_in);
        scrub_done_in <= 1'b0;
        #1 `CHK("scrub done", 7'h01, scrub_outstanding_out)
        for (n = 0; n < 9 && scrub_esc_tick_out !== 1'b1; n++)
            @(posedge mclk_in) #1;
        n = 0;
        do begin
            @(posedge mclk_in) #1;
            n++;
        end while (n < 9 && scrub_esc_tick_out !== 1'b1);
        `CHK("tick period", 4, n)
        $display("scrub test done");
    endtask
    task automatic t_cmd;
        gap(dat_pkg::cmd_activate, dat_pkg::cmd_read, 3'h0, 5);
        gap(dat_pkg::cmd_activate, dat_pkg::cmd_precharge, 3'h1, 14);
        gap(dat_pkg::cmd_refresh_all, dat_pkg::cmd_activate, 3'h2, 35);
        gap(dat_pkg::cmd_refresh_fine, dat_pkg::cmd_activate, 3'h3, 35);
        gap(dat_pkg::cmd_mode_read, dat_pkg::cmd_activate, 3'h4, 2);
        gap(dat_pkg::cmd_mode_write, dat_pkg::cmd_activate, 3'h5, 12);
        gap(dat_pkg::cmd_read, dat_pkg::cmd_power_down, 3'h6, 10);
        $display("command spacing test done");
    endtask

    task automatic end_sim;
        `CHK("model errors", 0, model_err)
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_regs;
        t_map;
        t_scrub;
        t_cmd;
        end_sim;
    end
endmodule
